// *** verilog/dhlc_cfg.svh ***
`ifndef DHLC_CFG_SVH
`define DHLC_CFG_SVH
// register byte offsets
`define DHLC_OFS_SRC1 8'h00
`define DHLC_OFS_ON1 8'h04
`define DHLC_OFS_OFF1 8'h08
`define DHLC_OFS_SRC2 8'h0C
`define DHLC_OFS_ON2 8'h10
`define DHLC_OFS_OFF2 8'h14
`define DHLC_OFS_ROUTE 8'h18
`define DHLC_OFS_STATUS 8'h1C
// reset values
`define DHLC_SRC_RST 5'h02
`define DHLC_ON_RST 16'h0064
`define DHLC_OFF_RST 16'h005A
`define DHLC_ROUTE_RST 8'h00
// limits, percent, two's complement
`define DHLC_LVL_MAX 16'h00FA
`define DHLC_LVL_MIN 16'hFF06
`define DHLC_SRC_LAST 5'h12
`define DHLC_SRC_NULL 5'h00
`define DHLC_SRC_FULL 5'h01
`define DHLC_RD_ERR 32'hDEADBEEF
`endif

// *** verilog/dhlc_pkg.sv ***
package dhlc_pkg;
    typedef logic signed [15:0] dhlc_level_t;
    typedef logic [4:0] dhlc_src_t;
    // relay route code per relay: 0 none, 1 first comparator, 2 second comparator
    typedef enum logic [1:0] {
        DHLC_ROUTE_NONE = 2'h0,
        DHLC_ROUTE_CMP1 = 2'h1,
        DHLC_ROUTE_CMP2 = 2'h2
    } dhlc_route_e;
    typedef enum logic [1:0] {
        DHLC_BUS_IDLE = 2'h1,
        DHLC_BUS_ACK = 2'h2
    } dhlc_bus_e;
endpackage : dhlc_pkg

// *** verilog/dhlc_cmp.sv ***
`timescale 1ns/1ps
`include "dhlc_cfg.svh"
module dhlc_cmp
    import dhlc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // selected level and thresholds
    input wire dhlc_level_t level,
    input wire dhlc_level_t on_level,
    input wire dhlc_level_t off_level,
    // result
    output logic cmp_out
);
    logic out_reg;
    logic out_next;

    always_comb begin
        out_next = out_reg;
        if (level >= on_level) begin
            out_next = 1'b1;
        end else if (level <= off_level) begin
            out_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign cmp_out = out_reg;

    AST_CMP_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
        (level >= on_level) |=> cmp_out)
        else $error("comparator failed to switch on");
    AST_CMP_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        (level <= off_level && level < on_level) |=> !cmp_out)
        else $error("comparator failed to switch off");
    AST_CMP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (level < on_level && level > off_level) |=> (cmp_out == $past(cmp_out)))
        else $error("comparator changed inside hysteresis band");
endmodule : dhlc_cmp

// *** verilog/dhlc_top.sv ***
`timescale 1ns/1ps
`include "dhlc_cfg.svh"
// How it works
// - two comparators each have their own source select taking codes 0 through 18.
// - code 0 gives a fixed minimum, code 1 a fixed full scale, codes 2 to 18 the internal quantities.
// - both source selects reset to code 2, output current.
// - each on threshold is held between its off threshold and +250 percent, reset 100.
// - each off threshold is held between -250 percent and its on threshold, reset 90.
// - an output turns on at or above its on threshold, off at or below its off threshold, else holds.
// - a relay follows a comparator only when its route selects that comparator.
module dhlc_top
    import dhlc_pkg::*;
#(
    parameter int NUM_RELAYS = 2,
    parameter int NUM_SRC = 19
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analogue quantities, codes 2..18 in slots 2..18, percent
    input wire logic [NUM_SRC*16-1:0] src_levels,
    // relay drive
    output logic [NUM_RELAYS-1:0] relay_out
);
    // ****************************************
    // registers
    // ****************************************
    dhlc_src_t src1_reg, src1_next, src2_reg, src2_next;
    dhlc_level_t on1_reg, on1_next, off1_reg, off1_next;
    dhlc_level_t on2_reg, on2_next, off2_reg, off2_next;
    logic [2*NUM_RELAYS-1:0] route_reg, route_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [NUM_RELAYS-1:0] relay_reg, relay_next;
    dhlc_bus_e bus_reg, bus_next;
    logic cmp1_out, cmp2_out;
    logic [31:0] wval;

    // each of the low two lanes lands only when enabled and is written as zero otherwise; upper lanes carry nothing
    assign wval = {16'h0000, (avs_byteenable[1] ? avs_writedata[15:8] : 8'h00),
                   (avs_byteenable[0] ? avs_writedata[7:0] : 8'h00)};

    function automatic dhlc_level_t clip(input dhlc_level_t v, input dhlc_level_t lo, input dhlc_level_t hi);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction : clip

    function automatic dhlc_src_t src_ok(input logic [31:0] v, input dhlc_src_t old);
        // out-of-range codes are dropped so the select never points past the table
        if (v[4:0] <= `DHLC_SRC_LAST && v[31:5] == 27'h0) begin
            return v[4:0];
        end
        return old;
    endfunction : src_ok

    // ****************************************
    // bus slave
    // ****************************************
    // one wait cycle: request taken while idle, answered next cycle with waitrequest low
    assign avs_waitrequest = (avs_read || avs_write) && (bus_reg != DHLC_BUS_ACK);
    assign avs_readdata = rdata_reg;

    always_comb begin
        src1_next = src1_reg;
        src2_next = src2_reg;
        on1_next = on1_reg;
        off1_next = off1_reg;
        on2_next = on2_reg;
        off2_next = off2_reg;
        route_next = route_reg;
        rdata_next = rdata_reg;
        bus_next = DHLC_BUS_IDLE;
        case (bus_reg)
            DHLC_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_next = DHLC_BUS_ACK;
                end
                if (avs_read) begin
                    case (avs_address)
                        `DHLC_OFS_SRC1: rdata_next = {27'h0, src1_reg};
                        `DHLC_OFS_ON1: rdata_next = {{16{on1_reg[15]}}, on1_reg};
                        `DHLC_OFS_OFF1: rdata_next = {{16{off1_reg[15]}}, off1_reg};
                        `DHLC_OFS_SRC2: rdata_next = {27'h0, src2_reg};
                        `DHLC_OFS_ON2: rdata_next = {{16{on2_reg[15]}}, on2_reg};
                        `DHLC_OFS_OFF2: rdata_next = {{16{off2_reg[15]}}, off2_reg};
                        `DHLC_OFS_ROUTE: rdata_next = 32'(route_reg);
                        `DHLC_OFS_STATUS: rdata_next = 32'({relay_reg, cmp2_out, cmp1_out});
                        default: rdata_next = `DHLC_RD_ERR;
                    endcase
                end
            end
            DHLC_BUS_ACK: begin
                // writes land at the answering edge, as the master samples waitrequest low
                if (avs_write) begin
                    case (avs_address)
                        `DHLC_OFS_SRC1: src1_next = src_ok(wval, src1_reg);
                        `DHLC_OFS_SRC2: src2_next = src_ok(wval, src2_reg);
                        `DHLC_OFS_ON1: on1_next = clip(wval[15:0], off1_reg, `DHLC_LVL_MAX);
                        `DHLC_OFS_ON2: on2_next = clip(wval[15:0], off2_reg, `DHLC_LVL_MAX);
                        `DHLC_OFS_OFF1: off1_next = clip(wval[15:0], `DHLC_LVL_MIN, on1_reg);
                        `DHLC_OFS_OFF2: off2_next = clip(wval[15:0], `DHLC_LVL_MIN, on2_reg);
                        `DHLC_OFS_ROUTE: route_next = wval[2*NUM_RELAYS-1:0];
                        default: ;
                    endcase
                end
            end
            default: bus_next = DHLC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src1_reg <= `DHLC_SRC_RST;
            src2_reg <= `DHLC_SRC_RST;
            on1_reg <= `DHLC_ON_RST;
            on2_reg <= `DHLC_ON_RST;
            off1_reg <= `DHLC_OFF_RST;
            off2_reg <= `DHLC_OFF_RST;
            route_reg <= '0;
            rdata_reg <= 32'h00000000;
            bus_reg <= DHLC_BUS_IDLE;
        end else begin
            src1_reg <= src1_next;
            src2_reg <= src2_next;
            on1_reg <= on1_next;
            on2_reg <= on2_next;
            off1_reg <= off1_next;
            off2_reg <= off2_next;
            route_reg <= route_next;
            rdata_reg <= rdata_next;
            bus_reg <= bus_next;
        end
    end

    // ****************************************
    // source selection and comparators
    // ****************************************
    // the table comes in as an argument: a continuous assignment only wakes on its own operands
    function automatic dhlc_level_t pick(input dhlc_src_t s, input logic [NUM_SRC*16-1:0] lv);
        if (s == `DHLC_SRC_NULL) begin
            return `DHLC_LVL_MIN;
        end else if (s == `DHLC_SRC_FULL) begin
            return `DHLC_LVL_MAX;
        end
        return lv[16*s +: 16];
    endfunction : pick

    dhlc_level_t lvl1, lvl2;
    assign lvl1 = pick(src1_reg, src_levels);
    assign lvl2 = pick(src2_reg, src_levels);

    dhlc_cmp u_cmp1 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .level(lvl1),
        .on_level(on1_reg),
        .off_level(off1_reg),
        .cmp_out(cmp1_out)
    );
    dhlc_cmp u_cmp2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .level(lvl2),
        .on_level(on2_reg),
        .off_level(off2_reg),
        .cmp_out(cmp2_out)
    );

    // ****************************************
    // relay routing
    // ****************************************
    always_comb begin
        relay_next = '0;
        for (int i = 0; i < NUM_RELAYS; i++) begin
            case (dhlc_route_e'(route_reg[2*i +: 2]))
                DHLC_ROUTE_CMP1: relay_next[i] = cmp1_out;
                DHLC_ROUTE_CMP2: relay_next[i] = cmp2_out;
                default: relay_next[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_reg <= '0;
        end else begin
            relay_reg <= relay_next;
        end
    end
    assign relay_out = relay_reg;

    AST_ON_ABOVE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
        (on1_reg >= off1_reg) && (on2_reg >= off2_reg) && (on1_reg <= dhlc_level_t'(`DHLC_LVL_MAX)))
        else $error("on threshold out of range");
    AST_OFF_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (off1_reg >= dhlc_level_t'(`DHLC_LVL_MIN)) && (off2_reg >= dhlc_level_t'(`DHLC_LVL_MIN)))
        else $error("off threshold below limit");
    AST_SRC_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (src1_reg <= `DHLC_SRC_LAST) && (src2_reg <= `DHLC_SRC_LAST))
        else $error("source code out of range");
    AST_NULL_SRC: assert property (@(posedge core_clk) disable iff (!rst_n)
        (src1_reg == `DHLC_SRC_NULL) |=> ##1 !cmp1_out || $past(src1_reg) != `DHLC_SRC_NULL)
        else $error("null source switched comparator on");
    AST_RST_DEFAULT: assert property (@(posedge core_clk)
        $rose(rst_n) |-> (src1_reg == `DHLC_SRC_RST) && (src2_reg == `DHLC_SRC_RST))
        else $error("source select reset value wrong");
    AST_ROUTE_NONE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (route_reg[1:0] == 2'h0) |=> !relay_out[0])
        else $error("unrouted relay driven");
    AST_ROUTE_CMP1: assert property (@(posedge core_clk) disable iff (!rst_n)
        (route_reg[1:0] == 2'h1) |=> (relay_out[0] == $past(cmp1_out)))
        else $error("relay not following first comparator");
    AST_CMP_EVAL: assert property (@(posedge core_clk) disable iff (!rst_n)
        (lvl2 >= on2_reg) |=> ##1 (relay_out[1] || route_reg[3:2] != 2'h2 || $past(route_reg[3:2]) != 2'h2))
        else $error("second comparator not evaluated");
endmodule : dhlc_top

// *** testbench/dhlc_relay_model.sv ***
`timescale 1ns/1ps
// ****
// relay coils seen from the far side
// ****
module dhlc_relay_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // coil drive
    input wire logic [1:0] relay_out,
    // changes of relay 0, counted so chatter shows up
    output logic [7:0] sw_cnt_reg
);
    logic coil_reg;
    logic coil_next;
    logic [7:0] sw_cnt_next;
    always_comb begin
        coil_next = relay_out[0];
        sw_cnt_next = sw_cnt_reg + {7'h00, coil_reg ^ relay_out[0]};
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            coil_reg <= 1'b0;
            sw_cnt_reg <= 8'h00;
        end else begin
            coil_reg <= coil_next;
            sw_cnt_reg <= sw_cnt_next;
        end
    end
endmodule : dhlc_relay_model

// *** testbench/dhlc_top_bench.sv ***
`timescale 1ns/1ps
`include "dhlc_cfg.svh"
module dhlc_top_bench
    import dhlc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [303:0] src_levels = '0;
    logic [1:0] relay_out;
    logic [7:0] sw_cnt;
    logic [31:0] q;
    int failures = 0;
    int n_checks = 0;
    always #50 core_clk = ~core_clk;
    dhlc_top dhlc_top_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_levels(src_levels),
        .relay_out(relay_out));
    dhlc_relay_model dhlc_relay_model_inst (.core_clk(core_clk), .rst_n(rst_n), .relay_out(relay_out),
        .sw_cnt_reg(sw_cnt));
    // ****
    // shared tasks
    // ****
    task automatic end_sim;
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // waitrequest is looked at mid-cycle so the edge that ends the transfer is known
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        do begin
            @(negedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        @(posedge core_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100)
            chk(32'h0, 32'h1);
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk
    // level to comparator one edge, comparator to relay one more
    task automatic lvl(input int n, input logic [15:0] v);
        @(posedge core_clk);
        src_levels[n*16 +: 16] <= v;
        repeat (3) @(posedge core_clk);
    endtask : lvl
    // ****
    // scenarios
    // ****
    localparam logic [7:0] OFS [8] = '{`DHLC_OFS_SRC1, `DHLC_OFS_ON1, `DHLC_OFS_OFF1, `DHLC_OFS_SRC2,
        `DHLC_OFS_ON2, `DHLC_OFS_OFF2, `DHLC_OFS_ROUTE, `DHLC_OFS_STATUS};
    localparam logic [31:0] RST [8] = '{32'h2, 32'h64, 32'h5A, 32'h2, 32'h64, 32'h5A, 32'h0, 32'h0};
    task automatic t_defaults;
        chk({30'h0, relay_out}, 32'h0);
        for (int i = 0; i < 8; i++)
            rd_chk(OFS[i], RST[i]);
        rd_chk(8'h20, 32'hDEADBEEF);
    endtask : t_defaults
    // odd slots far above the on level, even ones far below, so the status bit equals the code's low bit
    task automatic t_sources;
        for (int n = 0; n < 19; n++)
            src_levels[n*16 +: 16] <= n[0] ? 16'h00C8 : 16'hFF38;
        for (int n = 0; n < 19; n++) begin
            bus(1'b1, `DHLC_OFS_SRC1, n);
            repeat (3) @(posedge core_clk);
            rd_chk(`DHLC_OFS_SRC1, n);
            bus(1'b0, `DHLC_OFS_STATUS, 32'h0);
            chk({31'h0, q[0]}, {31'h0, n[0]});
        end
        bus(1'b1, `DHLC_OFS_SRC1, 32'h13);
        rd_chk(`DHLC_OFS_SRC1, 32'h12);
    endtask : t_sources
    localparam logic [15:0] LV [6] = '{16'h5F, 16'h64, 16'h5F, 16'h5B, 16'h5A, 16'h5F};
    localparam logic [1:0] EX [6] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
    task automatic t_window;
        logic [7:0] s0;
        bus(1'b1, `DHLC_OFS_SRC1, 32'h2);
        bus(1'b1, `DHLC_OFS_SRC2, 32'h3);
        bus(1'b1, `DHLC_OFS_OFF2, 32'hFFEC);
        bus(1'b1, `DHLC_OFS_ON2, 32'h14);
        rd_chk(`DHLC_OFS_OFF2, 32'hFFFFFFEC);
        bus(1'b1, `DHLC_OFS_ROUTE, 32'h9);
        lvl(3, 16'hFFE2);
        s0 = sw_cnt;
        for (int i = 0; i < 6; i++) begin
            lvl(2, LV[i]);
            chk({30'h0, relay_out}, {30'h0, EX[i]});
        end
        chk({24'h0, sw_cnt - s0}, 32'h2);
        lvl(3, 16'h0014);
        chk({30'h0, relay_out}, 32'h2);
        bus(1'b1, `DHLC_OFS_ROUTE, 32'h6);
        repeat (2) @(posedge core_clk);
        chk({30'h0, relay_out}, 32'h1);
        bus(1'b1, `DHLC_OFS_ROUTE, 32'hF);
        repeat (2) @(posedge core_clk);
        chk({30'h0, relay_out}, 32'h0);
    endtask : t_window
    task automatic t_clip;
        bus(1'b1, `DHLC_OFS_ON1, 32'h012C);
        rd_chk(`DHLC_OFS_ON1, 32'hFA);
        bus(1'b1, `DHLC_OFS_OFF1, 32'hFED4);
        rd_chk(`DHLC_OFS_OFF1, 32'hFFFFFF06);
        bus(1'b1, `DHLC_OFS_OFF1, 32'h0A);
        bus(1'b1, `DHLC_OFS_ON1, 32'h05);
        rd_chk(`DHLC_OFS_ON1, 32'h0A);
        bus(1'b1, `DHLC_OFS_OFF1, 32'h14);
        rd_chk(`DHLC_OFS_OFF1, 32'h0A);
        // upper lane disabled: only the low byte lands, the rest reads as zero
        avs_byteenable <= 4'h1;
        bus(1'b1, `DHLC_OFS_OFF1, 32'h0000FF05);
        avs_byteenable <= 4'hF;
        rd_chk(`DHLC_OFS_OFF1, 32'h05);
    endtask : t_clip
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_defaults;
        t_sources;
        t_window;
        t_clip;
        end_sim;
    end
    // the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        end_sim;
    end
endmodule : dhlc_top_bench
